// ===== fws_pkg.sv
// Package of constants, states and timings for the flash status polling controller
// Notes on behaviour
// - Host reads program status at the address being programmed.
// - Host polls sector erase inside an erased sector, chip erase at unprotected address.
// - Polling bit may settle before lower bits; host does a further read for data.
// - Host reads twice and compares toggle bit; unchanged means done.
// - Still toggling: check timeout flag, recheck toggle, on failure issue reset.
// - After leaving to do other work the host restarts from the first read pair.
// - On timeout flag set, host reads polling bit once more before declaring failure.
// - Reset command F0 to any address returns device to read mode after timeout.
package fws_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] RESET_CMD = 8'hF0;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int SECTOR_TOGGLE_BIT = 2;
    // Bus cycle timing in ns, turned into clock counts at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int READ_ACCESS_NS = 90;
    localparam int WRITE_PULSE_NS = 35;
    localparam int RECOVERY_NS = 30;
    localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    typedef enum logic [1:0] {
        FWS_CYC_IDLE,
        FWS_CYC_ACTIVE,
        FWS_CYC_RECOVER
    } fws_cyc_t;
    typedef enum logic [2:0] {
        FWS_ST_IDLE,
        FWS_ST_READ_A,
        FWS_ST_READ_B,
        FWS_ST_RECHECK,
        FWS_ST_DATA,
        FWS_ST_RESET,
        FWS_ST_DONE
    } fws_state_t;
    typedef enum logic [1:0] {
        FWS_RES_OK,
        FWS_RES_FAIL,
        FWS_RES_ABORT
    } fws_result_t;
endpackage

// ===== fws_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, timed in clock counts
`timescale 1ns/1ps
module fws_bus_cycle (
    input wire logic clk_in, // System clock
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic start_in, // Pulse: begin a cycle
    input wire logic write_in, // High for write, low for read
    input wire logic [fws_pkg::ADDR_W-1:0] addr_in, // Cycle address
    input wire logic [fws_pkg::DATA_W-1:0] wdata_in, // Write data
    input wire logic [fws_pkg::DATA_W-1:0] dq_in, // Data pins from flash
    output logic busy_out, // Cycle in progress
    output logic done_out, // Pulse: cycle finished
    output logic [fws_pkg::DATA_W-1:0] rdata_out, // Captured read data
    output logic [fws_pkg::ADDR_W-1:0] addr_out, // Address pins
    output logic [fws_pkg::DATA_W-1:0] dq_out, // Data pins to flash
    output logic dq_oe_out, // High while driving data pins
    output logic chip_sel_n_out, // Chip select, active low
    output logic write_n_out, // Write strobe, active low
    output logic out_en_n_out // Output strobe, active low
);
    fws_pkg::fws_cyc_t cyc_q;
    logic [fws_pkg::CNT_W-1:0] cnt_q;
    logic wr_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cyc_q <= fws_pkg::FWS_CYC_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
        end else begin
            unique case (cyc_q)
                fws_pkg::FWS_CYC_IDLE: begin
                    if (start_in) begin
                        cyc_q <= fws_pkg::FWS_CYC_ACTIVE;
                        wr_q <= write_in;
                        cnt_q <= write_in ? fws_pkg::CNT_W'(fws_pkg::WRITE_CYC - 1)
                                          : fws_pkg::CNT_W'(fws_pkg::READ_CYC - 1);
                    end
                end
                fws_pkg::FWS_CYC_ACTIVE: begin
                    if (cnt_q == '0) begin
                        cyc_q <= fws_pkg::FWS_CYC_RECOVER;
                        cnt_q <= fws_pkg::CNT_W'(fws_pkg::RECOV_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                fws_pkg::FWS_CYC_RECOVER: begin
                    if (cnt_q == '0) begin
                        cyc_q <= fws_pkg::FWS_CYC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            addr_out <= '0;
            dq_out <= '0;
        end else if (cyc_q == fws_pkg::FWS_CYC_IDLE && start_in) begin
            addr_out <= addr_in;
            dq_out <= wdata_in;
        end
    end

    // Sample at the end of the access time, before strobes rise
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= '0;
        end else if (cyc_q == fws_pkg::FWS_CYC_ACTIVE && cnt_q == '0 && !wr_q) begin
            rdata_out <= dq_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign busy_out = (cyc_q != fws_pkg::FWS_CYC_IDLE);
    assign done_out = (cyc_q == fws_pkg::FWS_CYC_RECOVER) && (cnt_q == '0);
    // Each read is framed by its own chip select pulse so the toggle bits advance
    assign chip_sel_n_out = (cyc_q != fws_pkg::FWS_CYC_ACTIVE);
    assign write_n_out = !((cyc_q == fws_pkg::FWS_CYC_ACTIVE) && wr_q);
    assign out_en_n_out = !((cyc_q == fws_pkg::FWS_CYC_ACTIVE) && !wr_q);
    assign dq_oe_out = (cyc_q != fws_pkg::FWS_CYC_IDLE) && wr_q;
endmodule

// ===== fws_poll_ctrl.sv
// Host-side controller that polls flash status after a program or erase
`timescale 1ns/1ps
module fws_poll_ctrl (
    input wire logic clk_in, // System clock
    input wire logic reset_in, // Synchronous reset, active high
    input wire logic start_in, // Pulse: begin status check
    input wire logic [fws_pkg::ADDR_W-1:0] status_addr_in, // Valid status address
    input wire logic use_polling_in, // High: polling bit method, low: toggle method
    input wire logic [fws_pkg::DATA_W-1:0] expect_data_in, // Data written, for polling method
    input wire logic abort_in, // Held high: leave polling for other work, taken once no bus cycle is running
    input wire logic [fws_pkg::DATA_W-1:0] dq_in, // Data pins from flash
    input wire logic ready_busy_in, // Ready/busy pin level, low is busy
    output logic busy_out, // Check in progress
    output logic done_out, // Pulse: result valid
    output logic [1:0] result_out, // Result code, held until the next done pulse
    output logic [fws_pkg::DATA_W-1:0] data_out, // Final array data on success
    output logic dev_busy_out, // Flash reports busy on its pin
    output logic [fws_pkg::ADDR_W-1:0] addr_out, // Address pins
    output logic [fws_pkg::DATA_W-1:0] dq_out, // Data pins to flash
    output logic dq_oe_out, // High while driving data pins
    output logic chip_sel_n_out, // Chip select, active low
    output logic write_n_out, // Write strobe, active low
    output logic out_en_n_out // Output strobe, active low
);
    fws_pkg::fws_state_t st_q;
    logic [fws_pkg::ADDR_W-1:0] addr_q;
    logic [fws_pkg::DATA_W-1:0] exp_q;
    logic [fws_pkg::DATA_W-1:0] first_q;
    logic poll_q;
    logic timeout_seen_q;
    logic cyc_start;
    logic cyc_write;
    logic cyc_busy;
    logic cyc_done;
    logic issued_q;
    logic [fws_pkg::DATA_W-1:0] rdata;
    logic toggled;
    logic poll_ok;
    logic timeout_hit;

    fws_bus_cycle u_cycle (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .start_in(cyc_start),
        .write_in(cyc_write),
        .addr_in(addr_q),
        .wdata_in(fws_pkg::RESET_CMD),
        .dq_in(dq_in),
        .busy_out(cyc_busy),
        .done_out(cyc_done),
        .rdata_out(rdata),
        .addr_out(addr_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out),
        .chip_sel_n_out(chip_sel_n_out),
        .write_n_out(write_n_out),
        .out_en_n_out(out_en_n_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // One bus cycle at a time; FWS_ST_READ_A and FWS_ST_READ_B relaunch after each cyc_done; issued_q stops a second launch before cyc_done
    // An abort taken in a launch cycle must not leave an orphan read on the bus
    assign cyc_start = (st_q != fws_pkg::FWS_ST_IDLE) && (st_q != fws_pkg::FWS_ST_DONE)
                       && !issued_q && !cyc_busy && !abort_in;
    assign cyc_write = (st_q == fws_pkg::FWS_ST_RESET);
    assign toggled = (rdata[fws_pkg::TOGGLE_BIT] != first_q[fws_pkg::TOGGLE_BIT]);
    assign poll_ok = (rdata[fws_pkg::POLL_BIT] == exp_q[fws_pkg::POLL_BIT]);
    assign timeout_hit = rdata[fws_pkg::TIMEOUT_BIT];
    assign busy_out = (st_q != fws_pkg::FWS_ST_IDLE) && (st_q != fws_pkg::FWS_ST_DONE);
    assign dev_busy_out = !ready_busy_in;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            issued_q <= 1'b0;
        end else if (cyc_done || abort_in) begin
            issued_q <= 1'b0;
        end else if (cyc_start) begin
            issued_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            addr_q <= '0;
            exp_q <= '0;
            poll_q <= 1'b0;
        end else if (start_in && !busy_out) begin
            addr_q <= status_addr_in;
            exp_q <= expect_data_in;
            poll_q <= use_polling_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            first_q <= '0;
        end else if (cyc_done && !cyc_write) begin
            first_q <= rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= fws_pkg::FWS_ST_IDLE;
            timeout_seen_q <= 1'b0;
            result_out <= 2'h0;
            data_out <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (abort_in && busy_out && !cyc_busy) begin
                // Leaving mid-check: a later start runs from the first read pair
                st_q <= fws_pkg::FWS_ST_DONE;
                result_out <= 2'(fws_pkg::FWS_RES_ABORT);
                done_out <= 1'b1;
            end else begin
                unique case (st_q)
                    fws_pkg::FWS_ST_IDLE, fws_pkg::FWS_ST_DONE: begin
                        if (start_in) begin
                            st_q <= fws_pkg::FWS_ST_READ_A;
                            timeout_seen_q <= 1'b0;
                        end
                    end
                    fws_pkg::FWS_ST_READ_A: begin
                        if (cyc_done) begin
                            if (poll_q && poll_ok) begin
                                st_q <= fws_pkg::FWS_ST_DATA;
                            end else if (poll_q && timeout_hit) begin
                                st_q <= fws_pkg::FWS_ST_RECHECK;
                            end else if (!poll_q) begin
                                st_q <= fws_pkg::FWS_ST_READ_B;
                            end
                        end
                    end
                    fws_pkg::FWS_ST_READ_B: begin
                        if (cyc_done) begin
                            if (!toggled) begin
                                st_q <= fws_pkg::FWS_ST_DATA;
                            end else if (timeout_seen_q) begin
                                st_q <= fws_pkg::FWS_ST_RESET;
                            end else if (timeout_hit) begin
                                timeout_seen_q <= 1'b1;
                            end
                        end
                    end
                    fws_pkg::FWS_ST_RECHECK: begin
                        if (cyc_done) begin
                            st_q <= poll_ok ? fws_pkg::FWS_ST_DATA : fws_pkg::FWS_ST_RESET;
                        end
                    end
                    fws_pkg::FWS_ST_DATA: begin
                        // Fresh read: lower bits may lag the status bit near completion
                        if (cyc_done) begin
                            data_out <= rdata;
                            result_out <= 2'(fws_pkg::FWS_RES_OK);
                            done_out <= 1'b1;
                            st_q <= fws_pkg::FWS_ST_DONE;
                        end
                    end
                    fws_pkg::FWS_ST_RESET: begin
                        if (cyc_done) begin
                            result_out <= 2'(fws_pkg::FWS_RES_FAIL);
                            done_out <= 1'b1;
                            st_q <= fws_pkg::FWS_ST_DONE;
                        end
                    end
                    default: begin
                        st_q <= fws_pkg::FWS_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ===== fws_flash_model.sv
// Behavioural flash device answering status reads during program and erase
`timescale 1ns/1ps
module fws_flash_model (
    input wire logic clk_in, // Bench clock, times the operation and samples the strobes
    input wire logic op_start_in, // Pulse: begin internal operation
    input wire logic op_erase_in, // High erase, low program
    input wire logic stuck_in, // High: never finishes
    input wire logic protect_in, // High: target sectors are protected
    input wire logic suspend_in, // High: erase is suspended
    input wire logic [7:0] prog_data_in, // Datum being programmed
    input wire logic [15:0] op_cycles_in, // Operation length in clocks
    input wire logic [7:0] dq_in, // Data from host
    input wire logic chip_sel_n_in, // Chip select, active low
    input wire logic write_n_in, // Write strobe, active low
    input wire logic out_en_n_in, // Output strobe, active low
    output logic [7:0] dq_out, // Data to host
    output logic ready_busy_out // Low while busy, high while an erase is suspended
);
    logic busy_q = 1'h0;
    logic erase_q = 1'h0;
    logic tog_q = 1'h0;
    logic sec_q = 1'h0;
    logic to_q = 1'h0;
    logic rd_q = 1'h1;
    logic wr_q = 1'h1;
    logic [15:0] cnt_q = 16'h0000;
    logic [7:0] last_q = 8'h00;
    logic [7:0] arr_q = 8'hFF;
    logic [7:0] want_q = 8'h00;
    logic held;
    ////////////////////////////////////////
    assign held = busy_q && erase_q && suspend_in;
    always_comb begin
        // Released bus shows the inverse so a stale sample cannot pass by chance
        if (chip_sel_n_in || out_en_n_in) begin
            dq_out = ~last_q;
        end else if (held) begin
            dq_out = {1'h1, tog_q, to_q, 2'h0, sec_q, 2'h0};
        end else if (busy_q) begin
            dq_out = {erase_q ? 1'h0 : ~want_q[7], tog_q, to_q, 2'h0, sec_q, 2'h0};
        end else begin
            dq_out = arr_q;
        end
    end
    assign ready_busy_out = !busy_q || held;
    always @(posedge clk_in) begin
        rd_q <= chip_sel_n_in || out_en_n_in;
        wr_q <= chip_sel_n_in || write_n_in;
        if (!(chip_sel_n_in || out_en_n_in)) begin
            last_q <= dq_out;
        end
        if (op_start_in) begin
            busy_q <= 1'h1;
            erase_q <= op_erase_in;
            want_q <= prog_data_in;
            // Protected targets keep their old contents; only the status window runs
            arr_q <= protect_in ? arr_q : (op_erase_in ? 8'hFF : prog_data_in);
            cnt_q <= op_cycles_in;
            to_q <= 1'h0;
        end else if (busy_q) begin
            if (held) begin
                cnt_q <= cnt_q;
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else if (stuck_in) begin
                to_q <= 1'h1;
            end else begin
                busy_q <= 1'h0;
            end
            if (!rd_q && (chip_sel_n_in || out_en_n_in)) begin
                tog_q <= tog_q ^ !held;
                sec_q <= sec_q ^ erase_q;
            end
            if (!wr_q && (chip_sel_n_in || write_n_in) && dq_in == 8'hF0) begin
                busy_q <= 1'h0;
            end
        end
    end
endmodule

// ===== fws_poll_chk.sv
// Checker of bus cycles and results of the status polling controller
`timescale 1ns/1ps
module fws_poll_chk (
    input wire logic clk_in, // Clock
    input wire logic reset_in, // Reset
    input wire logic start_in, // Start
    input wire logic [fws_pkg::ADDR_W-1:0] status_addr_in, // Status address
    input wire logic ready_busy_in, // Pin level
    input wire logic busy_out, // Busy
    input wire logic done_out, // Done
    input wire logic [1:0] result_out, // Result
    input wire logic dev_busy_out, // Device busy
    input wire logic [fws_pkg::ADDR_W-1:0] addr_out, // Address
    input wire logic [fws_pkg::DATA_W-1:0] dq_out, // Write data
    input wire logic dq_oe_out, // Drive enable
    input wire logic chip_sel_n_out, // Chip select
    input wire logic write_n_out, // Write strobe
    input wire logic out_en_n_out // Output strobe
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    logic [1:0] reads_q;
    always_ff @(posedge clk_in) begin
        if (reset_in || (start_in && !busy_out)) begin
            reads_q <= 2'h0;
        end else if ($fell(out_en_n_out) && reads_q != 2'h3) begin
            reads_q <= reads_q + 2'h1;
        end
    end
    sequence s_reset_write;
        !write_n_out ##1 write_n_out;
    endsequence
    ////////////////////////////////////////
    a_status_addr: assert property (!chip_sel_n_out |-> addr_out == status_addr_in)
        else $error("bus address differs from status address");
    a_read_frame: assert property ($fell(out_en_n_out) |-> (!chip_sel_n_out && !out_en_n_out && write_n_out) [*8])
        else $error("read strobe frame too short");
    a_strobe_excl: assert property (!(!write_n_out && !out_en_n_out))
        else $error("write and output strobes overlap");
    a_reset_code: assert property (!write_n_out |-> dq_oe_out && dq_out == fws_pkg::RESET_CMD)
        else $error("write cycle without reset code");
    a_pin_mirror: assert property (dev_busy_out == !ready_busy_in)
        else $error("device busy does not follow pin");
    a_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    a_start_taken: assert property (start_in && !busy_out |=> busy_out)
        else $error("start not taken");
    a_fail_reset: assert property (s_reset_write |-> ##[1:20] (done_out && result_out == 2'h1))
        else $error("reset write not followed by failure");
    a_ok_reads: assert property (done_out && result_out == 2'h0 |-> reads_q >= 2'h2)
        else $error("success after fewer than two reads");
    a_abort_quiet: assert property (done_out && result_out == 2'h2 |-> chip_sel_n_out)
        else $error("bus cycle left running after abort");
endmodule
bind fws_poll_ctrl fws_poll_chk i_chk (.clk_in, .reset_in, .start_in, .status_addr_in, .ready_busy_in, .busy_out,
    .done_out, .result_out, .dev_busy_out, .addr_out, .dq_out, .dq_oe_out, .chip_sel_n_out, .write_n_out,
    .out_en_n_out);

// ===== tb.sv
// Bench: status polling controller against the flash model
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic start_in = 1'h0;
    logic poll = 1'h0;
    logic abort_in = 1'h0;
    logic op_go = 1'h0;
    logic erase = 1'h0;
    logic hang = 1'h0;
    logic prot = 1'h0;
    logic susp = 1'h0;
    logic [7:0] wdata = 8'h00;
    logic [fws_pkg::ADDR_W-1:0] st_addr = 21'h012345;
    logic [fws_pkg::ADDR_W-1:0] addr;
    logic [7:0] dq_dev, dq_host, data;
    logic [1:0] res;
    logic busy, done, dev_busy, oe, cs_n, we_n, re_n, rdy;
    int errors = 0;
    int samples_checked = 0;
    always #2.5 clk_in = ~clk_in;
    fws_poll_ctrl i_dut (.clk_in, .reset_in, .start_in, .status_addr_in(st_addr), .use_polling_in(poll),
        .expect_data_in(wdata), .abort_in, .dq_in(dq_dev), .ready_busy_in(rdy), .busy_out(busy), .done_out(done),
        .result_out(res), .data_out(data), .dev_busy_out(dev_busy), .addr_out(addr), .dq_out(dq_host),
        .dq_oe_out(oe), .chip_sel_n_out(cs_n), .write_n_out(we_n), .out_en_n_out(re_n));
    fws_flash_model i_dev (.clk_in, .op_start_in(op_go), .op_erase_in(erase), .stuck_in(hang),
        .protect_in(prot), .suspend_in(susp),
        .prog_data_in(wdata), .op_cycles_in(16'h0190), .dq_in(dq_host), .chip_sel_n_in(cs_n),
        .write_n_in(we_n), .out_en_n_in(re_n), .dq_out(dq_dev), .ready_busy_out(rdy));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Device operation and status check are launched together, as right after a command
    task automatic run(input logic p, input logic e, input logic h, input logic a, input logic [7:0] d);
        int n;
        @(negedge clk_in);
        poll = p;
        erase = e;
        hang = h;
        wdata = d;
        abort_in = a;
        op_go = 1'h1;
        start_in = 1'h1;
        @(negedge clk_in);
        op_go = 1'h0;
        start_in = 1'h0;
        check(dev_busy, !susp);
        n = 0;
        while (done !== 1'h1 && n < 9000) begin
            @(negedge clk_in);
            n++;
        end
        check(done, 1'h1);
        check(busy, 1'h0);
        abort_in = 1'h0;
    endtask
    task automatic t_poll_erase();
        run(1'h1, 1'h1, 1'h0, 1'h0, 8'hFF);
        check(res, 2'h0);
        check(data, 8'hFF);
    endtask
    task automatic t_poll_timeout();
        run(1'h1, 1'h0, 1'h1, 1'h0, 8'h6E);
        check(res, 2'h1);
        repeat (2) @(negedge clk_in);
        check(dev_busy, 1'h0);
    endtask
    task automatic t_protect();
        prot = 1'h1;
        run(1'h0, 1'h0, 1'h0, 1'h0, 8'h3C);
        prot = 1'h0;
        check(res, 2'h0);
        check(data, 8'h81);
    endtask
    task automatic t_suspend();
        susp = 1'h1;
        run(1'h0, 1'h1, 1'h0, 1'h0, 8'hFF);
        check(res, 2'h0);
        check(data & 8'hB8, 8'h80);
        check(dev_busy, 1'h0);
        susp = 1'h0;
    endtask
    task automatic t_poll_prog();
        run(1'h1, 1'h0, 1'h0, 1'h0, 8'hA5);
        check(res, 2'h0);
        check(data, 8'hA5);
        check(dev_busy, 1'h0);
    endtask
    task automatic t_toggle_erase();
        run(1'h0, 1'h1, 1'h0, 1'h0, 8'h3C);
        check(res, 2'h0);
        check(data, 8'hFF);
    endtask
    task automatic t_timeout();
        run(1'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        check(res, 2'h1);
        repeat (2) @(negedge clk_in);
        check(dev_busy, 1'h0);
    endtask
    task automatic t_abort();
        run(1'h0, 1'h0, 1'h0, 1'h1, 8'h81);
        check(res, 2'h2);
        run(1'h0, 1'h0, 1'h0, 1'h0, 8'h81);
        check(res, 2'h0);
        check(data, 8'h81);
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        reset_in = 1'h0;
        t_poll_prog();
        t_poll_erase();
        t_toggle_erase();
        t_timeout();
        t_poll_timeout();
        t_abort();
        t_protect();
        t_suspend();
        conclude();
    end
    initial begin
        #100000;
        errors++;
        conclude();
    end
endmodule
